/* File: logic/sesp_core.v */
// Serial EEPROM port: pin sampling, decoder, array, programming timer
`timescale 1ns/1ps
`include "sesp_defs.vh"
module sesp_core #(
   parameter PROG_CYC = `SESP_PROG_CYC
) (
   input  wire clk,           // System clock, 50 MHz
   input  wire nrst,          // Async reset, active low
   input  wire chip_pick_n,   // Select pin, active low
   input  wire bit_tempo,     // Serial clock pin
   input  wire in_line,       // Serial data in
   input  wire pause_pin,     // Pause pin, active low
   input  wire prot_pin_n,    // Write protect, active low
   output reg  out_line,      // Serial data out
   output reg  out_line_oe,   // Drive enable for out_line
   output reg  standby_q      // Idle, low power indication
);
   // Decoder states
   localparam ST_INSTR = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_RDATA = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_SDATA = 3'h4;
   localparam ST_SOUT  = 3'h5;
   localparam ST_WAIT  = 3'h6;
   localparam [`SESP_CNT_W-1:0] PROG_LAST =
      PROG_CYC[`SESP_CNT_W-1:0] - {{(`SESP_CNT_W-1){1'b0}}, 1'b1};

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Assemble the status byte
   function [7:0] stat_byte;
      input [1:0] g;
      input       a;
      input       b;
      begin
         stat_byte = {`SESP_STAT_ONES, g, a, b};
      end
   endfunction

   // True when an address falls into the guarded range
   function guard_hit;
      input [1:0] g;
      input [7:0] a;
      begin
         case (g)
            `SESP_GUARD_QTR:  guard_hit = (a >= `SESP_QTR_BASE);
            `SESP_GUARD_HALF: guard_hit = (a >= `SESP_HALF_BASE);
            `SESP_GUARD_ALL:  guard_hit = 1'b1;
            default:          guard_hit = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: order is select, clock, data, pause, protect

   reg [4:0] m1_q;                // First stage, read only by m2
   reg [4:0] m2_q;                // Second stage
   reg       cs_d_q;              // Delayed select for edges
   reg       tmp_d_q;             // Delayed clock for edges
   reg       pau_d_q;             // Delayed pause for edges

   // Pins idle high except clock and data
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         m1_q    <= 5'h13;
         m2_q    <= 5'h13;
         cs_d_q  <= 1'b1;
         tmp_d_q <= 1'b0;
         pau_d_q <= 1'b1;
      end else begin
         m1_q    <= {chip_pick_n, bit_tempo, in_line, pause_pin,
                     prot_pin_n};
         m2_q    <= m1_q;
         cs_d_q  <= m2_q[4];
         tmp_d_q <= m2_q[3];
         pau_d_q <= m2_q[1];
      end
   end

   wire cs_s   = m2_q[4];
   wire tmp_s  = m2_q[3];
   wire din_s  = m2_q[2];
   wire pau_s  = m2_q[1];
   wire prot_s = m2_q[0];
   wire sel    = !cs_s;
   wire cs_up  = cs_s && !cs_d_q;
   wire cs_dn  = !cs_s && cs_d_q;

   ////////////////////////////////////////////////////////////////////////
   // Selection and pause

   reg seen_q;                    // A select fall has been seen
   reg paused_q;                  // Pause in force

   // Nothing is accepted before the first select fall
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         seen_q <= 1'b0;
      else if (cs_dn)
         seen_q <= 1'b1;
   end

   // Pause edges count only with the serial clock low
   // Pause survives a deselect; the decoder still resets
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         paused_q <= 1'b0;
      else if (sel && !tmp_s && !pau_s && pau_d_q)
         paused_q <= 1'b1;
      else if (sel && !tmp_s && pau_s && !pau_d_q)
         paused_q <= 1'b0;
   end

   // Clock edges are ignored while paused or deselected
   wire act  = sel && seen_q && !paused_q;
   wire rise = act && tmp_s && !tmp_d_q;     // Capture edge
   wire fall = act && !tmp_s && tmp_d_q;     // Launch edge

   ////////////////////////////////////////////////////////////////////////
   // Shared state

   reg [2:0]  state_q;            // Decoder state
   reg [2:0]  bitcnt_q;           // Bits within current byte
   reg [7:0]  sh_q;               // Input shifter
   reg [7:0]  addr_q;             // Array address
   reg [3:0]  pbase_q;            // Page being collected
   reg [15:0] mask_q;             // Page bytes received
   reg        rd_q;               // Address phase belongs to a read
   reg        got_q;              // A full data byte arrived
   reg [7:0]  sdat_q;             // Received status byte
   reg        arm_q;              // Write enable latch
   reg        busy_q;             // Programming in progress
   reg        kind_q;             // Cycle targets status when set
   reg [1:0]  guard_q;            // Non-volatile guard bits
   reg [`SESP_CNT_W-1:0] pcnt_q;  // Programming timer
   reg [7:0]  mem [0:255];        // Array
   reg [7:0]  page [0:15];        // Page latch
   reg [7:0]  osh_q;              // Output shifter
   reg [2:0]  ocnt_q;             // Bits left in output byte
   reg [3:0]  sent_q;             // Status bits shifted out
   reg        drv_q;              // Output is being driven

   wire [7:0] byte_in = {sh_q[6:0], din_s};  // MSB first
   wire       done    = rise && (bitcnt_q == `SESP_BIT_LAST);
   wire       wr_byte = done && (state_q == ST_WDATA);
   wire       sout_end = fall && (state_q == ST_SOUT) &&
                         (sent_q == `SESP_STAT_BITS);
   wire       prog_end = busy_q && (pcnt_q == {`SESP_CNT_W{1'b0}});

   // Prefetch buffer hand-shake
   wire       pf_ready;
   wire       pf_valid = sel && (state_q == ST_RDATA);
   wire       pf_take  = pf_valid && pf_ready;
   wire       ob_valid;
   wire [7:0] ob_data;
   wire       ob_pop = fall && (state_q == ST_RDATA) &&
                       (ocnt_q == 3'h0) && ob_valid;

   // Start conditions checked at the select rise
   wire bound  = got_q && (bitcnt_q == 3'h0) && arm_q && prot_s &&
                 seen_q && !paused_q;
   wire st_arr = cs_up && bound && (state_q == ST_WDATA) &&
                 !guard_hit(guard_q, {pbase_q, 4'h0});
   wire st_sta = cs_up && bound && (state_q == ST_SDATA);

   ////////////////////////////////////////////////////////////////////////
   // Instruction decoder and shifter

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= ST_INSTR;
         bitcnt_q <= 3'h0;
         sh_q     <= 8'h00;
         addr_q   <= 8'h00;
         pbase_q  <= 4'h0;
         mask_q   <= 16'h0000;
         rd_q     <= 1'b0;
         got_q    <= 1'b0;
         sdat_q   <= 8'h00;
      end else begin
         // Read address advances per prefetched byte, wraps
         if (pf_take)
            addr_q <= addr_q + 8'h01;
         if (!sel) begin
            // Deselect returns to awaiting an opcode
            state_q  <= ST_INSTR;
            bitcnt_q <= 3'h0;
            got_q    <= 1'b0;
         end else if (sout_end) begin
            state_q <= ST_WAIT;
         end else if (rise && state_q != ST_WAIT) begin
            sh_q     <= byte_in;
            bitcnt_q <= bitcnt_q + 3'h1;
            case (state_q)
               ST_INSTR: if (done) begin
                  case (byte_in)
                     `SESP_OP_ARM:   state_q <= ST_WAIT;
                     `SESP_OP_CLEAR: state_q <= ST_WAIT;
                     `SESP_OP_FETCH: state_q <= ST_SOUT;
                     `SESP_OP_STORE:
                        state_q <= busy_q ? ST_WAIT : ST_SDATA;
                     `SESP_OP_READ: begin
                        // Refused while programming
                        state_q <= busy_q ? ST_WAIT : ST_ADDR;
                        rd_q    <= 1'b1;
                     end
                     `SESP_OP_WRITE: begin
                        state_q <= busy_q ? ST_WAIT : ST_ADDR;
                        rd_q    <= 1'b0;
                     end
                     default: state_q <= ST_WAIT;
                  endcase
               end
               ST_ADDR: if (done) begin
                  addr_q  <= byte_in;
                  pbase_q <= byte_in[7:4];
                  mask_q  <= 16'h0000;
                  state_q <= rd_q ? ST_RDATA : ST_WDATA;
               end
               ST_WDATA: if (done) begin
                  // Low nibble wraps inside the page
                  got_q <= 1'b1;
                  mask_q[addr_q[3:0]] <= 1'b1;
                  addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
               end
               ST_SDATA: begin
                  if (got_q) begin
                     // Any clock past eight bits cancels
                     got_q   <= 1'b0;
                     state_q <= ST_WAIT;
                  end else if (done) begin
                     sdat_q <= byte_in;
                     got_q  <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write enable latch

   // Protect pin has top priority; set needs protect released
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         arm_q <= 1'b0;
      else if (!prot_s)
         arm_q <= 1'b0;
      else if (prog_end)
         arm_q <= 1'b0;
      else if (done && state_q == ST_INSTR) begin
         if (byte_in == `SESP_OP_ARM)
            arm_q <= 1'b1;
         else if (byte_in == `SESP_OP_CLEAR)
            arm_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Programming timer and guard bits

   // Once started, nothing but the timer ends the cycle
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_q  <= 1'b0;
         kind_q  <= 1'b0;
         pcnt_q  <= {`SESP_CNT_W{1'b0}};
         guard_q <= `SESP_GUARD_RST;
      end else if (busy_q) begin
         if (prog_end) begin
            busy_q <= 1'b0;
            if (kind_q)
               guard_q <= sdat_q[3:2];
         end else begin
            pcnt_q <= pcnt_q - {{(`SESP_CNT_W-1){1'b0}}, 1'b1};
         end
      end else if (st_arr || st_sta) begin
         busy_q <= 1'b1;
         kind_q <= st_sta;
         pcnt_q <= PROG_LAST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Page latch and array

   // Array is updated only at the end of a valid cycle
   always @(posedge clk) begin : arr_upd
      integer i;
      if (wr_byte)
         page[addr_q[3:0]] <= byte_in;
      if (prog_end && !kind_q) begin
         for (i = 0; i < `SESP_PAGE_N; i = i + 1) begin
            if (mask_q[i])
               mem[{pbase_q, i[3:0]}] <= page[i];
         end
      end
   end

   // Read bytes queue ahead so a slow receiver drops none
   sesp_buf2 #(
      .W (`SESP_BYTE_W)
   ) u_obuf (
      .clk       (clk),
      .nrst      (nrst),
      .flush     (!pf_valid),
      .in_valid  (pf_valid),
      .in_ready  (pf_ready),
      .in_data   (mem[addr_q]),
      .out_valid (ob_valid),
      .out_ready (ob_pop),
      .out_data  (ob_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output shifter; out_line changes only on the falling clock edge, status byte loads at the rise

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_line <= 1'b0;
         osh_q    <= 8'h00;
         ocnt_q   <= 3'h0;
         sent_q   <= 4'h0;
         drv_q    <= 1'b0;
      end else if (!sel || state_q == ST_WAIT) begin
         drv_q  <= 1'b0;
         ocnt_q <= 3'h0;
         sent_q <= 4'h0;
      end else if (done && state_q == ST_INSTR) begin
         // Status snapshot; old guards during status write
         osh_q  <= stat_byte(guard_q, arm_q, busy_q);
         sent_q <= 4'h0;
      end else if (fall && state_q == ST_SOUT) begin
         if (sent_q == `SESP_STAT_BITS) begin
            drv_q <= 1'b0;
         end else begin
            out_line <= osh_q[7];
            osh_q    <= {osh_q[6:0], 1'b0};
            sent_q   <= sent_q + 4'h1;
            drv_q    <= 1'b1;
         end
      end else if (fall && state_q == ST_RDATA) begin
         if (ocnt_q == 3'h0) begin
            if (ob_valid) begin
               out_line <= ob_data[7];
               osh_q    <= {ob_data[6:0], 1'b0};
               ocnt_q   <= `SESP_BIT_LAST;
               drv_q    <= 1'b1;
            end
         end else begin
            out_line <= osh_q[7];
            osh_q    <= {osh_q[6:0], 1'b0};
            ocnt_q   <= ocnt_q - 3'h1;
         end
      end
   end

   // Floating while deselected or paused; standby when deselected and not busy
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_line_oe <= 1'b0;
         standby_q   <= 1'b1;
      end else begin
         out_line_oe <= drv_q && sel && !paused_q;
         standby_q   <= !sel && !busy_q;
      end
   end
endmodule

/* File: logic/sesp_defs.vh */
// Constants for the serial EEPROM port: opcodes, status layout, timing
`ifndef SESP_DEFS_VH
`define SESP_DEFS_VH

// Instruction codes
`define SESP_OP_ARM      8'h06
`define SESP_OP_CLEAR    8'h04
`define SESP_OP_FETCH    8'h05
`define SESP_OP_STORE    8'h01
`define SESP_OP_READ     8'h03
`define SESP_OP_WRITE    8'h02

// Status layout and protection bounds
`define SESP_STAT_ONES   4'hF
`define SESP_GUARD_RST   2'h0
`define SESP_GUARD_NONE  2'h0
`define SESP_GUARD_QTR   2'h1
`define SESP_GUARD_HALF  2'h2
`define SESP_GUARD_ALL   2'h3
`define SESP_QTR_BASE    8'hC0
`define SESP_HALF_BASE   8'h80

// Bit and byte counts
`define SESP_BIT_LAST    3'h7
`define SESP_STAT_BITS   4'h8
`define SESP_BYTE_W      8
`define SESP_PAGE_N      16

// Programming time and clock rate
`define SESP_PROG_MS     10
`define SESP_CLK_HZ      50000000
`define SESP_PROG_CYC    (`SESP_PROG_MS * `SESP_CLK_HZ / 1000)
`define SESP_CNT_W       24

`endif

/* File: logic/sesp_buf2.v */
// Two-entry buffer between array prefetch and serial output shifter
`timescale 1ns/1ps
`include "sesp_defs.vh"
module sesp_buf2 #(
   parameter W = `SESP_BYTE_W
) (
   input  wire         clk,       // System clock
   input  wire         nrst,      // Async reset, active low
   input  wire         flush,     // Drop all entries
   input  wire         in_valid,  // Producer offers a word
   output wire         in_ready,  // Room for a word
   input  wire [W-1:0] in_data,   // Word offered
   output wire         out_valid, // A word is held
   input  wire         out_ready, // Consumer takes the word
   output wire [W-1:0] out_data   // Oldest word
);
   reg [W-1:0] ent_q [0:1];       // Storage
   reg         wp_q;              // Write slot
   reg         rp_q;              // Read slot
   reg [1:0]   cnt_q;             // Entries held

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = ent_q[rp_q];

   // Pointers and fill level; flush wins so stale bytes never leak
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else if (flush) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push)
            wp_q <= ~wp_q;
         if (pop)
            rp_q <= ~rp_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end

   // Data storage, no reset needed
   always @(posedge clk) begin
      if (push && !flush)
         ent_q[wp_q] <= in_data;
   end
endmodule

/* File: verification/sesp_core_asserts.sv */
// Port checker for the serial EEPROM port
`timescale 1ns/1ps
module sesp_core_asserts (
   input wire clk,         // System clock
   input wire nrst,        // Async reset, active low
   input wire chip_pick_n, // Select pin, active low
   input wire bit_tempo,   // Serial clock pin
   input wire in_line,     // Serial data in
   input wire pause_pin,   // Pause pin, active low
   input wire prot_pin_n,  // Write protect, active low
   input wire out_line,    // Serial data out
   input wire out_line_oe, // Drive enable for out_line
   input wire standby_q    // Idle indication
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   reset_quiet_a: assert property (
      $rose(nrst) |-> standby_q && !out_line_oe)
      else $error("not idle after reset");
   desel_float_a: assert property (
      chip_pick_n [*8] |-> !out_line_oe)
      else $error("output driven while deselected");
   sel_active_a: assert property (
      (!chip_pick_n) [*6] |-> !standby_q)
      else $error("standby while selected");
   out_change_a: assert property (
      $changed(out_line) && out_line_oe |-> !bit_tempo)
      else $error("output moved while clock high");
   oe_rise_a: assert property (
      $rose(out_line_oe) |-> !bit_tempo && !chip_pick_n && pause_pin)
      else $error("output enabled at a wrong moment");
   pause_float_a: assert property (
      !chip_pick_n && !bit_tempo && $fell(pause_pin)
      ##1 (!pause_pin) [*6] |-> !out_line_oe)
      else $error("output driven during pause");
   oe_short_a: assert property (
      $fell(out_line_oe) && !chip_pick_n && pause_pin
      |=> (!out_line_oe) [*8])
      else $error("output came back before deselect");
   busy_oe_a: assert property (
      $rose(chip_pick_n) ##1 chip_pick_n [*6] |-> !out_line_oe)
      else $error("output still driven after deselect");
endmodule

/* File: verification/sesp_master.sv */
// Bus master model driving the serial port pins in clock mode zero
`timescale 1ns/1ps
module sesp_master (
   input  wire clk,         // System clock
   input  wire out_line,    // Serial data from device
   input  wire out_line_oe, // Device drives out_line
   output reg  chip_pick_n, // Select, active low
   output reg  bit_tempo,   // Serial clock, idles low
   output reg  in_line,     // Serial data to device
   output reg  pause_pin,   // Pause, active low
   output reg  prot_pin_n   // Write protect, active low
);
   initial begin
      chip_pick_n = 1'b1; // High until the first fall
      bit_tempo   = 1'b0; // Mode zero idle level, stands still
      in_line     = 1'b0;
      pause_pin   = 1'b1;
      prot_pin_n  = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Select, then margin before the first rise
   task sel;
      begin
         @(posedge clk);
         chip_pick_n <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   // Low 5 clocks, high 3; data set well away from the rise
   task shift(input [7:0] tx, input integer n, output [7:0] rx,
              inout logic seen);
      integer i;
      begin
         rx = 8'h00;
         for (i = 0; i < n; i = i + 1) begin
            @(posedge clk);
            in_line <= tx[7-i];        // MSB first
            repeat (4) @(posedge clk);
            bit_tempo <= 1'b1;         // Device samples here
            repeat (3) @(posedge clk);
            // A released line shows no stale bit
            rx = {rx[6:0], out_line_oe ? out_line : ~out_line};
            seen = seen & out_line_oe;
            bit_tempo <= 1'b0;         // Device shifts after this
         end
      end
   endtask
   // Deselect in the low pulse right after the last bit
   task desel;
      begin
         @(posedge clk);
         chip_pick_n <= 1'b1;          // Ends write frames
         in_line     <= ~in_line;      // Released line shows no stale bit
         repeat (6) @(posedge clk);
      end
   endtask
   // Pause with the clock low, then resume
   task hold;
      begin
         @(posedge clk);
         pause_pin <= 1'b0;
         repeat (12) @(posedge clk);
         pause_pin <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule

/* File: verification/sesp_core_bench.sv */
// Self-checking bench for the serial EEPROM port
`timescale 1ns/1ps
`include "sesp_defs.vh"
module sesp_core_bench;
   localparam PROG = 400; // Short programming time, in clocks
   reg        clk;
   reg        nrst;
   wire       chip_pick_n;
   wire       bit_tempo;
   wire       in_line;
   wire       pause_pin;
   wire       prot_pin_n;
   wire       out_line;
   wire       out_line_oe;
   wire       standby_q;
   integer    n_mismatch = 0;
   integer    comparisons = 0;
   reg  [7:0] s;          // Status byte read back
   reg  [7:0] t;          // Scratch receive byte
   reg  [7:0] d [0:1];    // Data bytes read back
   reg        ok;         // Enable seen on every sampled bit
   sesp_core #(.PROG_CYC(PROG)) sesp_core_i (.clk(clk), .nrst(nrst),
      .chip_pick_n(chip_pick_n), .bit_tempo(bit_tempo),
      .in_line(in_line), .pause_pin(pause_pin),
      .prot_pin_n(prot_pin_n), .out_line(out_line),
      .out_line_oe(out_line_oe), .standby_q(standby_q));
   sesp_master sesp_master_i (.clk(clk), .out_line(out_line),
      .out_line_oe(out_line_oe), .chip_pick_n(chip_pick_n),
      .bit_tempo(bit_tempo), .in_line(in_line),
      .pause_pin(pause_pin), .prot_pin_n(prot_pin_n));
   ////////////////////////////////////////////////////////////
   task chk(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task stop_test;
      begin
         $display("mismatches %0d of %0d", n_mismatch, comparisons);
         if (n_mismatch == 0 && comparisons > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task sh(input [7:0] v, input integer n);
      sesp_master_i.shift(v, n, t, ok);
   endtask
   // Status read; ok keeps the enable after the ninth fall
   task stat;
      begin
         sesp_master_i.sel;
         sh(`SESP_OP_FETCH, 8);
         sh(8'h00, 8);
         s = t;
         repeat (6) @(posedge clk);
         ok = out_line_oe;
         sesp_master_i.desel;
      end
   endtask
   task cmd(input [7:0] op);
      begin
         sesp_master_i.sel;
         sh(op, 8);
         sesp_master_i.desel;
      end
   endtask
   task wr(input [7:0] a, input integer n, input [23:0] b);
      integer i;
      begin
         sesp_master_i.sel;
         sh(`SESP_OP_WRITE, 8);
         sh(a, 8);
         for (i = 0; i < n; i = i + 1)
            sh(b[23-8*i -: 8], 8);
         sesp_master_i.desel;
      end
   endtask
   // Read n bytes; optional pause after the first one
   task rd(input [7:0] a, input integer n, input pz);
      integer i;
      begin
         sesp_master_i.sel;
         sh(`SESP_OP_READ, 8);
         sh(a, 8);
         ok = 1'b1;
         for (i = 0; i < n; i = i + 1) begin
            sh(8'h00, 8);
            d[i] = t;
            if (pz && i == 0)
               sesp_master_i.hold;
         end
         sesp_master_i.desel;
      end
   endtask
   // Optional extra bit makes the frame the wrong length
   task store(input [7:0] v, input x);
      begin
         cmd(`SESP_OP_ARM);
         sesp_master_i.sel;
         sh(`SESP_OP_STORE, 8);
         sh(v, 8);
         if (x)
            sh(8'h00, 1);
         sesp_master_i.desel;
      end
   endtask
   // Bounded poll of the busy flag
   task idle;
      integer k;
      begin
         stat;
         for (k = 0; k < 20 && s[0] !== 1'b0; k = k + 1)
            stat;
         if (s[0] !== 1'b0) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t busy never cleared", $time);
            stop_test;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      nrst = 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk({6'h00, standby_q, out_line_oe}, 8'h02);
      stat;
      chk(s, 8'hF0);
      chk({7'h00, ok}, 8'h00);
      // Unknown opcode gets no answer
      sesp_master_i.sel;
      sh(8'hFF, 8);
      ok = 1'b1;
      sh(8'h00, 8);
      sesp_master_i.desel;
      chk({7'h00, ok}, 8'h00);
      cmd(`SESP_OP_ARM);
      stat;
      chk(s, 8'hF2);
      cmd(`SESP_OP_CLEAR);
      stat;
      chk(s, 8'hF0);
      wr(8'h0E, 1, 24'h5A0000);
      stat;
      chk(s, 8'hF0);
      // Page write wrapping, refused read while busy
      cmd(`SESP_OP_ARM);
      wr(8'h0E, 3, 24'h112233);
      rd(8'h0E, 1, 1'b0);
      chk({7'h00, ok}, 8'h00);
      stat;
      chk(s, 8'hF3);
      idle;
      chk(s, 8'hF0);
      cmd(`SESP_OP_ARM);
      wr(8'hFF, 1, 24'h5A0000);
      // Protect pin during the cycle must not abort it
      @(posedge clk);
      sesp_master_i.prot_pin_n <= 1'b0;
      idle;
      sesp_master_i.prot_pin_n <= 1'b1;
      rd(8'hFF, 2, 1'b1);
      chk(d[0], 8'h5A);
      chk(d[1], 8'h33);
      chk({7'h00, ok}, 8'h01);
      rd(8'h0E, 2, 1'b0);
      chk({d[0][3:0], d[1][3:0]}, 8'h12);
      // Guard bits: old values while the store runs
      store(8'h08, 1'b0);
      stat;
      chk(s, 8'hF3);
      idle;
      chk(s, 8'hF8);
      cmd(`SESP_OP_ARM);
      wr(8'hFF, 1, 24'hA50000);
      stat;
      chk({7'h00, s[0]}, 8'h00);
      rd(8'hFF, 1, 1'b0);
      chk(d[0], 8'h5A);
      store(8'h00, 1'b0);
      idle;
      store(8'h0C, 1'b1);
      stat;
      chk(s & 8'h0D, 8'h00);
      // Protect pin low clears the latch
      cmd(`SESP_OP_ARM);
      @(posedge clk);
      sesp_master_i.prot_pin_n <= 1'b0;
      stat;
      chk(s & 8'h0F, 8'h00);
      sesp_master_i.prot_pin_n <= 1'b1;
      stop_test;
   end
endmodule
bind sesp_core sesp_core_asserts sesp_core_asserts_i (.clk(clk),
   .nrst(nrst), .chip_pick_n(chip_pick_n), .bit_tempo(bit_tempo),
   .in_line(in_line), .pause_pin(pause_pin), .prot_pin_n(prot_pin_n),
   .out_line(out_line), .out_line_oe(out_line_oe),
   .standby_q(standby_q));
